// ==== verilog/vrsrc_card.sv ====
// card-side recording control: groups, slots, suspend address, unit timing
// assumes the host holds the link words stable across a link clock rise
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - suspend between units saves next address
// - suspend mid-unit releases all, zeroes address
// - no active group: suspend keeps address
// - host: directory update, resume, start
// - host: zero address means fresh group
// - write to suspended group zeroes address
// - eight slots, set and freed by id
// - host pads files to whole units
// - slot and index reassigned while recording
// - rate kept across unit and group boundaries
// - past group end no rate kept
// - free group becomes active, written sequentially
// - reads behind write pointer return data
// - group size at most 512MB
// - recording unit fixed at 512KB
// - first sub-unit includes free-group busy
// - halted unit invalidates its sub-unit
// - other commands excluded from measurement
// - rate from longest sub-unit period
// - rate holds regardless of table updates
// - violating commands end recording
// - commands zero to eleven end recording
module vrsrc_card #(
    parameter int AU_BLOCKS = 8192,
    parameter int SU_BLOCKS = 2048,
    parameter int BUSY_CYC  = 4
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    vrsrc_link_if.dev                link,
    output logic [31:0]              suspend_resume_address,
    output logic                     recording,
    output logic                     group_active,
    output logic [vrsrc_pkg::SLOTS-1:0] slot_valid,
    output logic [31:0]              max_su_period
);
    // =========================================================
    // elaboration checks
    if (longint'(AU_BLOCKS) * vrsrc_pkg::BLK_BYTES > vrsrc_pkg::GROUP_MAX_BYTES) begin : g_big
        $error("group size too large");
    end
    if (AU_BLOCKS % vrsrc_pkg::RU_BLOCKS != 0 || AU_BLOCKS % SU_BLOCKS != 0) begin : g_ru
        $error("group not a whole number of units");
    end
    if ((SU_BLOCKS & (SU_BLOCKS - 1)) != 0 || BUSY_CYC < 1) begin : g_su
        $error("bad sub-unit size or busy count");
    end
    localparam int RU_W = $clog2(vrsrc_pkg::RU_BLOCKS);
    localparam logic [31:0] AU_SZ = 32'(AU_BLOCKS);
    localparam logic [31:0] SU_MASK = 32'(SU_BLOCKS - 1);
    localparam logic [15:0] BUSY_N = 16'(BUSY_CYC);
    localparam int SW = 2 + 6 + 4 + 3 + 32 + 16;

    // =========================================================
    // link sampling
    logic [SW-1:0] s;
    logic          lc_prev;
    vrsrc_sync #(.W(SW)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        ({link.link_clk, link.req, link.cmd_idx, link.fn, link.slot,
                    link.arg, link.cnt}),
        .q        (s)
    );
    wire        s_lc   = s[SW-1];
    wire        s_req  = s[SW-2];
    wire [5:0]  s_cmd  = s[SW-3 -: 6];
    wire [3:0]  s_fn   = s[SW-9 -: 4];
    wire [2:0]  s_slot = s[SW-13 -: 3];
    wire [31:0] s_arg  = s[47:16];
    wire [15:0] s_cnt  = s[15:0];
    wire        rise   = s_lc & ~lc_prev;

    // =========================================================
    // control state
    typedef enum logic [1:0] {D_IDLE, D_BUSY, D_ACK} vrsrc_dst_e;
    vrsrc_dst_e  st, next_st;
    logic [15:0] bcnt, next_bcnt;
    logic        ack, next_ack, rd_ok, next_rd_ok;
    logic        rec, next_rec, act, next_act, susp, next_susp;
    logic        started, next_started, meas, next_meas, was_wr, next_was_wr;
    logic        su_ok, next_su_ok;
    logic [31:0] base, next_base, nxt, next_nxt, sus, next_sus, sus_base, next_sus_base;
    logic [31:0] su_t, next_su_t, max_t, next_max_t;
    logic [RU_W-1:0] ru_off, next_ru_off;
    logic [vrsrc_pkg::SLOTS-1:0] slot_v, next_slot_v;
    logic [31:0] slot_a [vrsrc_pkg::SLOTS];
    logic [31:0] next_slot_a [vrsrc_pkg::SLOTS];

    function automatic logic in_grp(input logic [31:0] a, input logic [31:0] b);
        return (a >= b) && (a - b < AU_SZ);
    endfunction : in_grp

    always_comb begin
        next_st = st; next_bcnt = bcnt; next_ack = ack; next_rd_ok = rd_ok;
        next_rec = rec; next_act = act; next_susp = susp; next_started = started;
        next_meas = meas; next_was_wr = was_wr; next_su_ok = su_ok;
        next_base = base; next_nxt = nxt; next_sus = sus; next_sus_base = sus_base;
        next_su_t = su_t; next_max_t = max_t; next_ru_off = ru_off;
        next_slot_v = slot_v;
        next_slot_a = slot_a;
        unique case (st)
            D_IDLE: begin
                if (rise && s_req) begin
                    next_st = D_BUSY;
                    next_bcnt = BUSY_N;
                    next_meas = 1'b0;
                    next_was_wr = 1'b0;
                    if (vrsrc_pkg::vrsrc_violating(s_cmd)) begin
                        next_rec = 1'b0;
                        next_act = 1'b0;
                        next_slot_v = '0;
                    end else if (s_cmd == vrsrc_pkg::CMD_REC) begin
                        unique case (s_fn)
                            vrsrc_pkg::FN_START: begin
                                next_rec = 1'b1;
                                next_started = 1'b1;
                            end
                            vrsrc_pkg::FN_UPD_DIR: begin
                                next_slot_v[s_slot] = 1'b1;
                                next_slot_a[s_slot] = s_arg;
                            end
                            vrsrc_pkg::FN_REL_DIR: next_slot_v[s_slot] = 1'b0;
                            vrsrc_pkg::FN_SET_FREE: begin
                                next_act = 1'b1;
                                next_base = s_arg;
                                next_nxt = s_arg;
                                next_ru_off = '0;
                                next_susp = 1'b0;
                                next_su_t = '0;
                                next_su_ok = 1'b1;
                                next_meas = started;
                            end
                            vrsrc_pkg::FN_SUSPEND: begin
                                next_slot_v = '0;
                                if (act) begin
                                    next_act = 1'b0;
                                    next_rec = 1'b0;
                                    if (ru_off != '0) begin
                                        next_sus = '0;
                                    end else if (in_grp(nxt, base)) begin
                                        next_sus = nxt;
                                        next_susp = 1'b1;
                                        next_sus_base = base;
                                    end else begin
                                        next_sus = '0;
                                    end
                                end
                            end
                            vrsrc_pkg::FN_RESUME: begin
                                if (susp && sus != '0) begin
                                    next_act = 1'b1;
                                    next_base = sus_base;
                                    next_nxt = sus;
                                    next_susp = 1'b0;
                                    next_su_t = '0;
                                    next_su_ok = 1'b1;
                                end
                            end
                            default: ;
                        endcase
                    end else if (s_cmd == vrsrc_pkg::CMD_WR) begin
                        if (susp && in_grp(s_arg, sus_base))
                            next_sus = '0;
                        next_bcnt = (s_cnt == '0) ? 16'h0001 : s_cnt;
                        if (act && in_grp(s_arg, base)) begin
                            if (s_arg != nxt) begin
                                next_rec = 1'b0;
                                next_act = 1'b0;
                            end else begin
                                next_nxt = nxt + 32'(s_cnt);
                                next_ru_off = ru_off + RU_W'(s_cnt);
                                if (RU_W'(s_cnt) != '0)
                                    next_su_ok = 1'b0;
                                next_meas = rec;
                                next_was_wr = 1'b1;
                                if (nxt + 32'(s_cnt) - base >= AU_SZ)
                                    next_act = 1'b0;
                            end
                        end
                    end else if (s_cmd == vrsrc_pkg::CMD_RD) begin
                        next_rd_ok = !(act && in_grp(s_arg, base)) || (s_arg < nxt);
                    end
                end
            end
            D_BUSY: begin
                if (meas)
                    next_su_t = su_t + 32'h0000_0001;
                next_bcnt = bcnt - 16'h0001;
                if (bcnt == 16'h0001) begin
                    next_st = D_ACK;
                    next_ack = 1'b1;
                    if (was_wr && ((nxt - base) & SU_MASK) == '0) begin
                        if (su_ok && su_t >= max_t)
                            next_max_t = su_t + 32'(meas);
                        next_su_t = '0;
                        next_su_ok = 1'b1;
                    end
                end
            end
            D_ACK: begin
                if (!s_req) begin
                    next_st = D_IDLE;
                    next_ack = 1'b0;
                end
            end
            default: next_st = D_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= D_IDLE; bcnt <= '0; ack <= 1'b0; rd_ok <= 1'b0; lc_prev <= 1'b0;
            rec <= 1'b0; act <= 1'b0; susp <= 1'b0; started <= 1'b0;
            meas <= 1'b0; was_wr <= 1'b0; su_ok <= 1'b1;
            base <= '0; nxt <= '0; sus <= '0; sus_base <= '0;
            su_t <= '0; max_t <= '0; ru_off <= '0; slot_v <= '0;
            for (int i = 0; i < vrsrc_pkg::SLOTS; i++)
                slot_a[i] <= '0;
        end else begin
            st <= next_st; bcnt <= next_bcnt; ack <= next_ack; rd_ok <= next_rd_ok;
            lc_prev <= s_lc;
            rec <= next_rec; act <= next_act; susp <= next_susp; started <= next_started;
            meas <= next_meas; was_wr <= next_was_wr; su_ok <= next_su_ok;
            base <= next_base; nxt <= next_nxt; sus <= next_sus; sus_base <= next_sus_base;
            su_t <= next_su_t; max_t <= next_max_t; ru_off <= next_ru_off;
            slot_v <= next_slot_v;
            slot_a <= next_slot_a;
        end
    end

    // =========================================================
    // outputs, all straight from flops
    assign link.ack = ack;
    assign link.resp_sus = sus;
    assign link.resp_rec = rec;
    assign link.resp_rd_ok = rd_ok;
    assign suspend_resume_address = sus;
    assign recording = rec;
    assign group_active = act;
    assign slot_valid = slot_v;
    assign max_su_period = max_t;
endmodule : vrsrc_card

// ==== include/vrsrc_pkg.sv ====
// shared constants for the recording suspend/resume control link
// assumes 512-byte blocks and 32-bit block addresses
package vrsrc_pkg;
    // =========================================================
    // widths and link command set
    localparam int         ADDR_W     = 32;
    localparam int         CNT_W      = 16;
    localparam int         SLOTS      = 8;
    localparam logic [5:0] CMD_REC    = 6'h14;
    localparam logic [5:0] CMD_WR     = 6'h19;
    localparam logic [5:0] CMD_RD     = 6'h12;
    typedef enum logic [3:0] {
        FN_START, FN_UPD_DIR, FN_UPD_CI, FN_SUSPEND, FN_RESUME, FN_SET_FREE, FN_REL_DIR
    } vrsrc_fn_e;
    // =========================================================
    // sizes
    localparam int      BLK_BYTES       = 512;
    localparam int      RU_BYTES        = 524288;
    localparam int      RU_BLOCKS       = RU_BYTES / BLK_BYTES;
    localparam longint  GROUP_MAX_BYTES = 64'h0000_0000_2000_0000;
    // =========================================================
    // timing
    localparam int      CORE_PERIOD_NS  = 10;
    localparam int      LINK_PERIOD_NS  = 160;
    localparam int      LINK_HALF_CYC   = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
    // =========================================================
    // host register map and fields
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_ARG    = 4'h1;
    localparam logic [3:0] REG_CNT    = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_SUS    = 4'h4;
    localparam int      CMD_GO_BIT    = 31;
    localparam int      CMD_SLOT_LSB  = 16;
    localparam int      CMD_FN_LSB    = 8;
    localparam int      ST_BUSY_BIT   = 0;
    localparam int      ST_REC_BIT    = 1;
    localparam int      ST_RDOK_BIT   = 2;
    localparam int      ST_ERR_BIT    = 3;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // commands that end a recording
    function automatic logic vrsrc_violating(input logic [5:0] c);
        return (c <= 6'h0b) || (c >= 6'h0e && c <= 6'h10) || (c == 6'h16)
            || (c >= 6'h1a && c <= 6'h1f) || (c == 6'h27) || (c >= 6'h29 && c <= 6'h2f)
            || (c == 6'h33) || (c == 6'h38) || (c >= 6'h3c);
    endfunction : vrsrc_violating
endpackage : vrsrc_pkg

// ==== include/vrsrc_link_if.sv ====
// link between the recording host controller and the card control
// assumes the bench resolves nothing: all link wires are one-way
`timescale 1ns/1ps
interface vrsrc_link_if;
    logic        link_clk;
    logic        req;
    logic [5:0]  cmd_idx;
    logic [3:0]  fn;
    logic [2:0]  slot;
    logic [31:0] arg;
    logic [15:0] cnt;
    logic        ack;
    logic [31:0] resp_sus;
    logic        resp_rec;
    logic        resp_rd_ok;
    modport host (output link_clk, req, cmd_idx, fn, slot, arg, cnt,
                  input  ack, resp_sus, resp_rec, resp_rd_ok);
    modport dev  (input  link_clk, req, cmd_idx, fn, slot, arg, cnt,
                  output ack, resp_sus, resp_rec, resp_rd_ok);
endinterface : vrsrc_link_if

// ==== verilog/vrsrc_sync.sv ====
// two-flop synchroniser for a bus of slow, stable-held levels
// assumes each bit changes rarely compared with clk
`timescale 1ns/1ps
module vrsrc_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;
    always_comb begin
        next_meta = rst_n ? d : '0;
        next_q    = rst_n ? meta : '0;
    end
    always_ff @(posedge core_clk) begin
        meta <= next_meta;
        q    <= next_q;
    end
endmodule : vrsrc_sync

// ==== verilog/vrsrc_host.sv ====
// host controller end: register port in, link commands out
// assumes software polls the status busy bit before each new command
`timescale 1ns/1ps
module vrsrc_host (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    vrsrc_link_if.host       link,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata
);
    localparam int SW = 1 + 32 + 2;
    localparam logic [7:0] HALF_N = 8'(vrsrc_pkg::LINK_HALF_CYC);
    localparam logic [15:0] RU_MASK = 16'(vrsrc_pkg::RU_BLOCKS - 1);
    typedef enum logic [1:0] {H_IDLE, H_REQ, H_DROP} vrsrc_hst_e;

    // =========================================================
    // answer sampling
    logic [SW-1:0] s;
    vrsrc_sync #(.W(SW)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        ({link.ack, link.resp_sus, link.resp_rec, link.resp_rd_ok}),
        .q        (s)
    );
    wire s_ack = s[SW-1];

    // =========================================================
    // state
    vrsrc_hst_e  st, next_st;
    logic [7:0]  div, next_div;
    logic        lc, next_lc, req, next_req, pend, next_pend, err, next_err;
    logic        dir_seen, next_dir_seen;
    logic [31:0] cmd_r, next_cmd_r, arg_r, next_arg_r, sus_c, next_sus_c;
    logic [15:0] cnt_r, next_cnt_r;
    logic        rec_c, next_rec_c, rdok_c, next_rdok_c;
    logic [31:0] rdata_r, next_rdata_r;
    wire         fall = lc && div == '0;
    wire [3:0]   wfn  = wdata[vrsrc_pkg::CMD_FN_LSB +: 4];
    wire         wrec = wdata[5:0] == vrsrc_pkg::CMD_REC;

    always_comb begin
        next_st = st; next_req = req; next_pend = pend; next_err = err;
        next_dir_seen = dir_seen; next_cmd_r = cmd_r; next_arg_r = arg_r;
        next_cnt_r = cnt_r; next_sus_c = sus_c; next_rec_c = rec_c; next_rdok_c = rdok_c;
        next_div = (div == '0) ? HALF_N - 8'h01 : div - 8'h01;
        next_lc = (div == '0) ? ~lc : lc;
        next_rdata_r = '0;
        if (rd) begin
            unique case (addr)
                vrsrc_pkg::REG_CMD:    next_rdata_r = cmd_r;
                vrsrc_pkg::REG_ARG:    next_rdata_r = arg_r;
                vrsrc_pkg::REG_CNT:    next_rdata_r = {16'h0000, cnt_r};
                vrsrc_pkg::REG_STATUS: next_rdata_r = {28'h0000000, err, rdok_c, rec_c,
                                                       pend || st != H_IDLE};
                vrsrc_pkg::REG_SUS:    next_rdata_r = sus_c;
                default:               next_rdata_r = '0;
            endcase
        end
        if (wr && addr == vrsrc_pkg::REG_ARG) next_arg_r = wdata;
        if (wr && addr == vrsrc_pkg::REG_CNT) next_cnt_r = wdata[15:0];
        if (wr && addr == vrsrc_pkg::REG_CMD && !pend && st == H_IDLE) begin
            next_cmd_r = {1'b0, wdata[30:0]};
            next_err = 1'b0;
            if (wrec && wfn == vrsrc_pkg::FN_RESUME && (sus_c == '0 || !dir_seen))
                next_err = 1'b1;
            else if (wdata[5:0] == vrsrc_pkg::CMD_WR && (cnt_r & RU_MASK) != '0)
                next_err = 1'b1;
            else
                next_pend = wdata[vrsrc_pkg::CMD_GO_BIT];
            if (wrec && wfn == vrsrc_pkg::FN_UPD_DIR && wdata[vrsrc_pkg::CMD_GO_BIT])
                next_dir_seen = 1'b1;
            if (wrec && wfn == vrsrc_pkg::FN_RESUME && !next_err)
                next_dir_seen = 1'b0;
        end
        unique case (st)
            H_IDLE: if (pend && fall) begin
                next_req = 1'b1;
                next_pend = 1'b0;
                next_st = H_REQ;
            end
            H_REQ: if (s_ack && fall) begin
                next_req = 1'b0;
                {next_sus_c, next_rec_c, next_rdok_c} = s[SW-2:0];
                next_st = H_DROP;
            end
            H_DROP: if (!s_ack) next_st = H_IDLE;
            default: next_st = H_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= H_IDLE; div <= '0; lc <= 1'b0; req <= 1'b0; pend <= 1'b0;
            err <= 1'b0; dir_seen <= 1'b0; cmd_r <= vrsrc_pkg::REG_RESET;
            arg_r <= vrsrc_pkg::REG_RESET; cnt_r <= '0; sus_c <= '0;
            rec_c <= 1'b0; rdok_c <= 1'b0; rdata_r <= '0;
        end else begin
            st <= next_st; div <= next_div; lc <= next_lc; req <= next_req;
            pend <= next_pend; err <= next_err; dir_seen <= next_dir_seen;
            cmd_r <= next_cmd_r; arg_r <= next_arg_r; cnt_r <= next_cnt_r;
            sus_c <= next_sus_c; rec_c <= next_rec_c; rdok_c <= next_rdok_c;
            rdata_r <= next_rdata_r;
        end
    end

    // =========================================================
    // outputs; req only changes on a link clock fall, link words change on register writes
    assign link.link_clk = lc;
    assign link.req = req;
    assign link.cmd_idx = cmd_r[5:0];
    assign link.fn = cmd_r[vrsrc_pkg::CMD_FN_LSB +: 4];
    assign link.slot = cmd_r[vrsrc_pkg::CMD_SLOT_LSB +: 3];
    assign link.arg = arg_r;
    assign link.cnt = cnt_r;
    assign rdata = rdata_r;
endmodule : vrsrc_host

// ==== bench/vrsrc_checker.sv ====
// link assertions between host and card
// assumes link signals come from core clock flops
`timescale 1ns/1ps
module vrsrc_checker (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        link_clk,
    input wire logic        req,
    input wire logic [5:0]  cmd_idx,
    input wire logic [3:0]  fn,
    input wire logic [2:0]  slot,
    input wire logic [31:0] arg,
    input wire logic [15:0] cnt,
    input wire logic        ack,
    input wire logic [31:0] resp_sus,
    input wire logic        resp_rec,
    input wire logic        resp_rd_ok
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ====
    // cycles spent waiting for an answer
    logic [10:0] wait_cyc;
    always_ff @(posedge core_clk) begin
        if (!rst_n || !req || ack)
            wait_cyc <= 11'h000;
        else if (wait_cyc != 11'h7ff)
            wait_cyc <= wait_cyc + 11'h001;
    end
    // ====
    // handshake
    a_ack_needs_req: assert property ($rose(ack) |-> req) else $error("ack without req");
    a_req_idle: assert property ($rose(req) |-> !ack && !link_clk) else $error("req early");
    a_words_held: assert property (req && $past(req) |-> $stable({cmd_idx, fn, slot, arg, cnt}))
        else $error("words moved");
    a_ack_release: assert property ($fell(req) |-> ##[1:8] !ack) else $error("ack stuck");
    a_ack_bound: assert property (req |-> wait_cyc < 11'h4b0) else $error("no ack");
    a_clk_high: assert property ($rose(link_clk) |-> link_clk[*8] ##1 !link_clk)
        else $error("link clock width");
    a_resp_held: assert property (ack && $past(ack) |-> $stable({resp_sus, resp_rec, resp_rd_ok}))
        else $error("resp moved");
    a_violating_stop: assert property ($rose(ack) && cmd_idx <= 6'h0b |-> !resp_rec)
        else $error("recording kept");
    c_write: cover property ($rose(ack) && cmd_idx == vrsrc_pkg::CMD_WR);
    c_suspend: cover property ($rose(ack) && fn == vrsrc_pkg::FN_SUSPEND);
    c_stop: cover property ($rose(ack) && cmd_idx == 6'h00);
endmodule : vrsrc_checker

// ==== bench/vrsrc_bench.sv ====
// host and card back to back, driven through the register port
// assumes the handed-over register map
`timescale 1ns/1ps
module vrsrc_bench;
    logic        core_clk, rst_n, wr, rd, rec, grp;
    logic [3:0]  addr;
    logic [7:0]  sv;
    logic [31:0] wdata, rdata, sus, mx, v;
    int          failures, n_tests, cyc;
    vrsrc_link_if lnk ();
    vrsrc_host u_vrsrc_host (.core_clk(core_clk), .rst_n(rst_n), .link(lnk.host),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    vrsrc_card #(.AU_BLOCKS(2048), .SU_BLOCKS(512), .BUSY_CYC(1)) u_vrsrc_card (
        .core_clk(core_clk), .rst_n(rst_n), .link(lnk.dev), .suspend_resume_address(sus),
        .recording(rec), .group_active(grp), .slot_valid(sv), .max_su_period(mx));
    vrsrc_checker u_vrsrc_checker (.core_clk(core_clk), .rst_n(rst_n), .link_clk(lnk.link_clk),
        .req(lnk.req), .cmd_idx(lnk.cmd_idx), .fn(lnk.fn), .slot(lnk.slot), .arg(lnk.arg),
        .cnt(lnk.cnt), .ack(lnk.ack), .resp_sus(lnk.resp_sus), .resp_rec(lnk.resp_rec),
        .resp_rd_ok(lnk.resp_rd_ok));
    // ====
    // access tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        @(posedge core_clk);
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(posedge core_clk);
        d = rdata;
    endtask : rreg
    task automatic cmd(input logic [5:0] c, input logic [3:0] f, input logic [2:0] s,
                       input logic [31:0] a, input logic [15:0] n);
        wreg(vrsrc_pkg::REG_ARG, a);
        wreg(vrsrc_pkg::REG_CNT, {16'h0, n});
        wreg(vrsrc_pkg::REG_CMD, {1'b1, 12'h0, s, 4'h0, f, 2'h0, c});
        v = 32'h1;
        for (int i = 0; i < 3000 && v[0] !== 1'b0; i++) rreg(vrsrc_pkg::REG_STATUS, v);
        chk("busy", {31'h0, v[0]}, 32'h0);
    endtask : cmd
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    // ====
    // clock, timeout, scenarios
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        {rst_n, wr, rd, addr, wdata, failures, n_tests} = '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rreg(4'h7, v);
        chk("unmapped", v, 32'h0);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_SUSPEND, 3'h0, 32'h0, 16'h0);
        chk("sus idle", sus, 32'h0);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_UPD_DIR, 3'h2, 32'h40, 16'h0);
        chk("slot two", {24'h0, sv}, 32'h4);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_START, 3'h0, 32'h0, 16'h0);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_SET_FREE, 3'h0, 32'h800, 16'h0);
        chk("group", {31'h0, grp}, 32'h1);
        cmd(vrsrc_pkg::CMD_WR, 4'h0, 3'h0, 32'h800, 16'h0400);
        chk("period", {31'h0, mx != 0}, 32'h1);
        cmd(vrsrc_pkg::CMD_RD, 4'h0, 3'h0, 32'h800, 16'h1);
        chk("read ok", {31'h0, v[2]}, 32'h1);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_SUSPEND, 3'h0, 32'h0, 16'h0);
        rreg(vrsrc_pkg::REG_SUS, v);
        chk("sus next", v, 32'hc00);
        chk("slots freed", {24'h0, sv}, 32'h0);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_UPD_DIR, 3'h1, 32'h40, 16'h0);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_RESUME, 3'h0, 32'h0, 16'h0);
        chk("resume", {31'h0, v[3]}, 32'h0);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_START, 3'h0, 32'h0, 16'h0);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_SUSPEND, 3'h0, 32'h0, 16'h0);
        chk("sus again", sus, 32'hc00);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_SUSPEND, 3'h0, 32'h0, 16'h0);
        chk("sus kept", sus, 32'hc00);
        cmd(vrsrc_pkg::CMD_WR, 4'h0, 3'h0, 32'hc00, 16'h0400);
        chk("sus cleared", sus, 32'h0);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_RESUME, 3'h0, 32'h0, 16'h0);
        chk("resume refused", {31'h0, v[3]}, 32'h1);
        cmd(vrsrc_pkg::CMD_WR, 4'h0, 3'h0, 32'h2000, 16'h0200);
        chk("pad refused", {31'h0, v[3]}, 32'h1);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_SET_FREE, 3'h0, 32'h2000, 16'h0);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_START, 3'h0, 32'h0, 16'h0);
        cmd(vrsrc_pkg::CMD_RD, 4'h0, 3'h0, 32'h2400, 16'h1);
        chk("read unwritten", {31'h0, v[2]}, 32'h0);
        for (int s = 3; s < 8; s += 4) cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_UPD_DIR, 3'(s),
            32'h80, 16'h0);
        cmd(vrsrc_pkg::CMD_REC, vrsrc_pkg::FN_REL_DIR, 3'h3, 32'h0, 16'h0);
        chk("slot release", {24'h0, sv}, 32'h80);
        cmd(6'h00, 4'h0, 3'h0, 32'h0, 16'h0);
        chk("stopped", {16'h0, sv, 6'h0, grp, rec}, 32'h0);
        wrap_up();
    end
endmodule : vrsrc_bench
